/* File: core/pfc_cfg.svh */
// Constants for the parallel flash host controller.
// Assumes inclusion by bare name from the core folder.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
// Register byte offsets on the Avalon slave
`define PFC_REG_CTRL 4'h0
`define PFC_REG_ADDR 4'h4
`define PFC_REG_DATA 4'h8
`define PFC_REG_STAT 4'hc
// Control field positions
`define PFC_CTRL_GO 0
`define PFC_CTRL_OP_LO 1
`define PFC_CTRL_OP_HI 3
`define PFC_CTRL_WORD 4
`define PFC_CTRL_HV_ID 5
`define PFC_CTRL_HV_RST 6
`define PFC_CTRL_PAGE 7
// Status field positions
`define PFC_STAT_BUSY 0
`define PFC_STAT_DONE 1
`define PFC_STAT_TMO 2
`define PFC_STAT_FAIL 3
// Reset values
`define PFC_CTRL_RST 8'h10
// Command codes sent on the flash bus
`define PFC_UNLOCK1_ADDR 21'h000555
`define PFC_UNLOCK1_DATA 16'h00aa
`define PFC_UNLOCK2_ADDR 21'h0002aa
`define PFC_UNLOCK2_DATA 16'h0055
`define PFC_PROG_DATA 16'h00a0
`define PFC_RESET_DATA 16'h00f0
// Strobe timing
`define PFC_T_ACC_NS 70
`define PFC_T_WP_NS 35
`define PFC_CLK_NS 10
`define PFC_ACC_CYC ((`PFC_T_ACC_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_WP_CYC ((`PFC_T_WP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_POLL_LIMIT 4000
`endif

/* File: core/pfc_pkg.sv */
// Types for the parallel flash host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_OP_READ,
    PFC_OP_PROGRAM,
    PFC_OP_RESET,
    PFC_OP_HV_ID,
    PFC_OP_PROT_CHK
  } pfc_op_t;
  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic width_select_n;
    logic [19:0] addr;
  } pfc_pins_t;
endpackage

/* File: core/pfc_strobe.sv */
// One flash bus cycle: read or write with stretched strobes.
// Assumes a flash whose read and write timings fit the cycle counts.
`include "pfc_cfg.svh"
module pfc_strobe
  import pfc_pkg::*;
#(
  parameter int CYC = `PFC_ACC_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Request
  input wire logic start,
  input wire logic is_write,
  output logic busy,
  output logic done,
  // Strobe outputs
  output logic strobe_n,
  output logic sample
);
  logic [7:0] count;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
      strobe_n <= 1'b1;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && count == 8'h00) begin
        count <= 8'(CYC + 1);
        strobe_n <= 1'b0;
      end else if (count == 8'h01) begin
        count <= 8'h00;
        done <= 1'b1;
      end else if (count != 8'h00) begin
        count <= count - 8'h01;
        if (count == 8'h02) begin
          strobe_n <= 1'b1;
        end
      end
    end
  end
  assign busy = count != 8'h00;
  assign sample = !is_write && count == 8'h02;
endmodule

/* File: core/pfc_host.sv */
// Host controller driving an asynchronous parallel NOR flash.
// Assumes a bench resolving data pins from the output enables.
// Behaviour
// [R1] Width select high gives sixteen active data lines.
// [R2] Width select low uses eight lines; line fifteen carries the LSB address.
// [R3] Chip select high puts the flash in standby, outputs floating.
// [R4] After power-up the flash reads array data without commands.
// [R5] After embedded program or erase the flash returns to array reads.
// [R6] In erase suspend, suspended sectors read status, others array data.
// [R7] Host writes reset command after timeout flag or leaving identification; the code writes it only when software issues the reset operation.
// [R8] Chip select or output enable high floats the flash outputs.
// [R9] High-voltage identification: qualifier low, selects pick maker or part.
// [R10] Protect check: sector on high address, select high set, low clear.
// [R11] Host drives page line high while reading the maker code.
// [R12] Identification also reachable by command without high voltage.
// [R13] Program is four writes: two unlocks, set-up, address with data.
// [R14] Flash times its own program pulses after the last write.
// [R15] Program end releases latched address and resumes array reads.
// [R16] During programming status reads show polling and toggle flags.
// [R17] Commands written during programming are ignored.
// [R18] Program addresses may come in any order, across sectors.
// [R19] Programming never turns 0 into 1; only erase can.
// [R20] Protected sectors reject program and erase.
// [R21] High voltage on hard clear temporarily unprotects sectors.
// [R22] Protect every other sector before an unprotect operation.
// [R23] High voltage on a pin is modelled by a separate qualifier.
`include "pfc_cfg.svh"
module pfc_host
  import pfc_pkg::*;
#(
  parameter int POLL_LIMIT = `PFC_POLL_LIMIT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Flash pins
  output pfc_pins_t flash_pins,
  output logic [14:0] dq_out,
  output logic dq_oe_n,
  input wire logic [14:0] dq_in,
  output logic upper_data_or_lsb_address_out,
  output logic upper_data_or_lsb_address_oe_n,
  input wire logic upper_data_or_lsb_address_in,
  output logic id_enable_hv,
  output logic hard_clear_hv
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CYCLE, ST_NEXT, ST_POLL, ST_FIN
  } pfc_state_t;
  pfc_state_t state;
  logic [7:0] ctrl;
  logic [20:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] rdata;
  logic busy_f, done_f, tmo_f, fail_f;
  logic [1:0] step;
  logic [15:0] polls;
  logic cyc_start, cyc_done, cyc_sample, strobe_n, cyc_busy;
  logic cyc_write;
  logic [20:0] cyc_addr;
  logic [15:0] cyc_data;
  logic [15:0] bus_in;
  logic prev_toggle;
  pfc_op_t op;
  logic word_mode;
  assign op = pfc_op_t'(ctrl[`PFC_CTRL_OP_HI:`PFC_CTRL_OP_LO]);
  assign word_mode = ctrl[`PFC_CTRL_WORD];
  pfc_strobe #(.CYC(`PFC_ACC_CYC)) u_strobe (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(cyc_start),
    .is_write(cyc_write),
    .busy(cyc_busy),
    .done(cyc_done),
    .strobe_n(strobe_n),
    .sample(cyc_sample)
  );
  // Avalon: one wait cycle on reads, writes answered at once
  logic rd_wait;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_wait <= 1'b0;
    end else if (clk_en) begin
      rd_wait <= avs_read && !rd_wait;
    end
  end
  assign avs_waitrequest = (avs_read && !rd_wait) || !clk_en;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en && avs_read && !rd_wait) begin
      case (avs_address)
        `PFC_REG_CTRL: avs_readdata <= {24'h000000, ctrl};
        `PFC_REG_ADDR: avs_readdata <= {11'h000, addr_reg};
        `PFC_REG_DATA: avs_readdata <= {16'h0000, rdata};
        `PFC_REG_STAT: avs_readdata <= {28'h0000000, fail_f, tmo_f, done_f, busy_f};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
  logic go;
  assign go = avs_write && !avs_waitrequest && avs_address == `PFC_REG_CTRL
    && avs_writedata[`PFC_CTRL_GO] && state == ST_IDLE;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `PFC_CTRL_RST;
      addr_reg <= 21'h000000;
      data_reg <= 16'h0000;
    end else if (clk_en && avs_write && !avs_waitrequest && !busy_f) begin
      case (avs_address)
        `PFC_REG_CTRL: ctrl <= {avs_writedata[7:1], 1'b0};
        `PFC_REG_ADDR: addr_reg <= avs_writedata[20:0];
        `PFC_REG_DATA: data_reg <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end
  // Bus cycle sequencing per operation
  always_comb begin
    cyc_write = 1'b0;
    cyc_addr = addr_reg;
    cyc_data = data_reg;
    case (op)
      PFC_OP_PROGRAM: begin
        cyc_write = state != ST_POLL; // R13
        case (step)
          2'd0: begin cyc_addr = `PFC_UNLOCK1_ADDR; cyc_data = `PFC_UNLOCK1_DATA; end
          2'd1: begin cyc_addr = `PFC_UNLOCK2_ADDR; cyc_data = `PFC_UNLOCK2_DATA; end
          2'd2: begin cyc_addr = `PFC_UNLOCK1_ADDR; cyc_data = `PFC_PROG_DATA; end
          default: ;
        endcase
      end
      PFC_OP_RESET: begin
        cyc_write = 1'b1; // R7
        cyc_data = `PFC_RESET_DATA;
      end
      PFC_OP_HV_ID: begin
        cyc_addr = {addr_reg[20:10], 1'b0, ctrl[`PFC_CTRL_PAGE], 1'b0, 1'b0,
          addr_reg[5:2], 1'b0, addr_reg[0]}; // R9 R11
      end
      PFC_OP_PROT_CHK: begin
        cyc_addr = {addr_reg[20:10], 1'b0, addr_reg[8:7], 1'b0, addr_reg[5:2],
          2'b10}; // R10
      end
      default: ;
    endcase
  end
  // Status polling reuses the read cycle until the program completes
  assign cyc_start = (state == ST_CYCLE || state == ST_POLL) && !cyc_busy && !cyc_done;
  assign bus_in = {upper_data_or_lsb_address_in, dq_in};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      step <= 2'd0;
      polls <= 16'h0000;
      busy_f <= 1'b0;
      done_f <= 1'b0;
      tmo_f <= 1'b0;
      fail_f <= 1'b0;
      rdata <= 16'h0000;
      prev_toggle <= 1'b0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            state <= ST_CYCLE;
            step <= 2'd0;
            polls <= 16'h0000;
            busy_f <= 1'b1;
            done_f <= 1'b0;
            tmo_f <= 1'b0;
            fail_f <= 1'b0;
          end
        end
        ST_CYCLE: begin
          if (cyc_sample) begin
            rdata <= word_mode ? bus_in : {8'h00, bus_in[7:0]}; // R1 R2
          end
          if (cyc_done) begin
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (op == PFC_OP_PROGRAM && step != 2'd3) begin
            step <= step + 2'd1;
            state <= ST_CYCLE;
          end else if (op == PFC_OP_PROGRAM) begin
            state <= ST_POLL; // R14
          end else begin
            state <= ST_FIN;
          end
        end
        ST_POLL: begin
          // Status read: toggle flag stable ends it; polling flag unequal to data bit 7 sets fail
          if (cyc_sample) begin
            rdata <= bus_in;
            prev_toggle <= bus_in[6];
            polls <= polls + 16'h0001;
            if (polls != 16'h0000 && bus_in[6] == prev_toggle) begin
              state <= ST_FIN; // R16 R15
              fail_f <= bus_in[7] != data_reg[7];
            end else if (bus_in[5] || polls == 16'(POLL_LIMIT)) begin
              state <= ST_FIN;
              tmo_f <= 1'b1; // R7
              fail_f <= 1'b1;
            end
          end
        end
        ST_FIN: begin
          busy_f <= 1'b0;
          done_f <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // Pin drive; data outputs float whenever not writing, except line fifteen which byte mode always drives
  logic active;
  assign active = cyc_busy;
  always_comb begin
    flash_pins.chip_select_n = !active; // R3 R8
    flash_pins.output_enable_n = !(active && !cyc_write) || strobe_n;
    flash_pins.write_enable_n = !(active && cyc_write) || strobe_n;
    flash_pins.width_select_n = word_mode; // R1 R2
    flash_pins.addr = word_mode ? cyc_addr[19:0] : cyc_addr[20:1];
  end
  assign dq_out = cyc_data[14:0];
  assign dq_oe_n = !(active && cyc_write);
  assign upper_data_or_lsb_address_out = word_mode ? cyc_data[15] : cyc_addr[0]; // R2
  assign upper_data_or_lsb_address_oe_n = word_mode ? !(active && cyc_write) : 1'b0;
  assign id_enable_hv = op == PFC_OP_HV_ID || op == PFC_OP_PROT_CHK; // R23 R9
  // Software level only; other sectors should be protected beforehand
  assign hard_clear_hv = ctrl[`PFC_CTRL_HV_RST]; // R21 R22
endmodule

/* File: dv/pfc_host_assertions.sv */
// Pin-level checks on the flash host controller.
// Assumes binding into pfc_host with one clock domain.
module pfc_host_assertions
  import pfc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Flash pins
  input wire pfc_pins_t flash_pins,
  input wire logic dq_oe_n,
  input wire logic upper_data_or_lsb_address_oe_n,
  input wire logic id_enable_hv
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_no_contention: assert property (!dq_oe_n |-> flash_pins.output_enable_n)
    else $error("Host drives data during read");
  chk_strobe_select: assert property (!flash_pins.output_enable_n ||
    !flash_pins.write_enable_n |-> !flash_pins.chip_select_n) else $error("Strobe unselected");
  chk_write_data: assert property (!flash_pins.write_enable_n |-> !dq_oe_n)
    else $error("Write without data");
  chk_byte_lsb: assert property (!flash_pins.width_select_n |-> !upper_data_or_lsb_address_oe_n)
    else $error("Byte address bit not driven");
  chk_word_upper: assert property (flash_pins.width_select_n &&
    !flash_pins.output_enable_n |-> upper_data_or_lsb_address_oe_n) else $error("Upper line fight");
  chk_hv_qualifier: assert property (id_enable_hv && !flash_pins.chip_select_n
    |-> !flash_pins.addr[6]) else $error("Qualifier high in identification");
  chk_read_hold: assert property ($fell(flash_pins.output_enable_n)
    |-> !flash_pins.output_enable_n[*7]) else $error("Read strobe too short");
  chk_addr_steady: assert property (!flash_pins.output_enable_n &&
    $past(!flash_pins.output_enable_n) |-> $stable(flash_pins.addr)) else $error("Address moved");
  cover property ($fell(flash_pins.write_enable_n));
  cover property ($fell(flash_pins.output_enable_n) && id_enable_hv);
  cover property (!flash_pins.width_select_n && !flash_pins.output_enable_n);
endmodule
bind pfc_host pfc_host_assertions u_chk (.core_clk, .reset_n, .flash_pins, .dq_oe_n,
  .upper_data_or_lsb_address_oe_n, .id_enable_hv);

/* File: dv/pfc_flash_model.sv */
// Behavioural flash device facing the host controller.
// Assumes word addresses on pins; sectors with addr[19] set are protected.
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5d, // Arbitrary value
  parameter logic [7:0] CONT_CODE = 8'h6e // Arbitrary value
) (
  // Pins from host
  input wire pfc_pins_t flash_pins,
  input wire logic [14:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic upper_data_or_lsb_address_out,
  input wire logic upper_data_or_lsb_address_oe_n,
  input wire logic id_enable_hv,
  input wire logic hard_clear_hv,
  // Resolved pins to host
  output logic [14:0] dq_in,
  output logic upper_data_or_lsb_address_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [16];
  logic [15:0] q, wd;
  logic [19:0] wa;
  logic [3:0] ix;
  logic [1:0] step = 2'h0;
  logic tgl = 1'b0;
  logic rd, up;
  int busy = 0;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h5a00 | 16'(i);
  assign ix = {flash_pins.addr[19], flash_pins.addr[2:0]};
  assign up = upper_data_or_lsb_address_out;
  always @* if (!flash_pins.write_enable_n && !flash_pins.chip_select_n) begin
    wa = flash_pins.addr;
    wd = {up, dq_out};
  end
  always @(posedge flash_pins.write_enable_n) begin
    if (busy > 0) step = step;
    else if (step == 2'h3) begin
      if (!wa[19] || hard_clear_hv) mem[{wa[19], wa[2:0]}] &= wd;
      if (!wa[19] || hard_clear_hv) busy = 3;
      step = 2'h0;
    end else if (wd[7:0] == 8'haa && wa[10:0] == 11'h555) step = 2'h1;
    else if (step == 2'h1 && wd[7:0] == 8'h55 && wa[10:0] == 11'h2aa) step = 2'h2;
    else if (step == 2'h2 && wd[7:0] == 8'ha0) step = 2'h3;
    else step = 2'h0;
  end
  always @(posedge flash_pins.output_enable_n) if (busy > 0) begin
    tgl = !tgl;
    busy = busy - 1;
  end
  always @* begin
    if (busy > 0) q = {8'h00, ~mem[ix][7], tgl, 6'h00};
    else if (id_enable_hv && !flash_pins.addr[6]) begin
      case (flash_pins.addr[1:0])
        2'h0: q = {8'h00, flash_pins.addr[8] ? MAKER_CODE : CONT_CODE};
        2'h1: q = {8'h00, PART_CODE};
        2'h2: q = {15'h0000, flash_pins.addr[19]};
        default: q = 16'h0000;
      endcase
    end else if (flash_pins.width_select_n) q = mem[ix];
    else q = {8'h00, up ? mem[ix][15:8] : mem[ix][7:0]};
  end
  assign rd = !flash_pins.chip_select_n && !flash_pins.output_enable_n;
  assign dq_in[7:0] = !dq_oe_n ? dq_out[7:0] : rd ? q[7:0] : ~dq_out[7:0];
  assign dq_in[14:8] = !dq_oe_n ? dq_out[14:8]
    : rd && flash_pins.width_select_n ? q[14:8] : ~dq_out[14:8];
  assign upper_data_or_lsb_address_in = !upper_data_or_lsb_address_oe_n ? up
    : rd && flash_pins.width_select_n ? q[15] : ~up;
endmodule

/* File: dv/pfc_host_tb.sv */
// Self-checking bench for the parallel flash host controller.
// Assumes the behavioural flash model on the far pins.
`include "pfc_cfg.svh"
module pfc_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0] op;
    logic [20:0] a;
    logic [15:0] d;
    logic [3:0] m;
    logic [15:0] q;
    logic c;
  } pfc_row_t;
  pfc_row_t rows [15] = '{'{3'h0, 21'h3, 16'h0, 4'h1, 16'h5a03, 1'b1},
    '{3'h1, 21'h4, 16'h0f0f, 4'h1, 16'h0, 1'b0}, '{3'h0, 21'h4, 16'h0, 4'h1, 16'h0a04, 1'b1},
    '{3'h1, 21'h080001, 16'h0, 4'h1, 16'h0, 1'b0},
    '{3'h0, 21'h080001, 16'h0, 4'h1, 16'h5a09, 1'b1},
    '{3'h1, 21'h080001, 16'h00ff, 4'h5, 16'h0, 1'b0},
    '{3'h0, 21'h080001, 16'h0, 4'h1, 16'h0009, 1'b1},
    '{3'h3, 21'h200, 16'h0, 4'h9, 16'h003c, 1'b1}, '{3'h3, 21'h0, 16'h0, 4'h1, 16'h006e, 1'b1},
    '{3'h3, 21'h1, 16'h0, 4'h9, 16'h005d, 1'b1}, '{3'h4, 21'h080000, 16'h0, 4'h1, 16'h1, 1'b1},
    '{3'h4, 21'h4, 16'h0, 4'h1, 16'h0, 1'b1}, '{3'h2, 21'h0, 16'h0, 4'h1, 16'h0, 1'b0},
    '{3'h0, 21'h7, 16'h0, 4'h0, 16'h005a, 1'b1}, '{3'h0, 21'h6, 16'h0, 4'h0, 16'h0003, 1'b1}};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rv, st;
  logic avs_waitrequest, dq_oe_n, upper_data_or_lsb_address_out, upper_data_or_lsb_address_oe_n;
  logic upper_data_or_lsb_address_in, id_enable_hv, hard_clear_hv;
  logic [14:0] dq_out, dq_in;
  pfc_pkg::pfc_pins_t flash_pins;
  int bad_count = 0;
  int check_count = 0;
  pfc_host #(.POLL_LIMIT(10)) u_dut (.core_clk, .reset_n, .clk_en, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .flash_pins,
    .dq_out, .dq_oe_n, .dq_in, .upper_data_or_lsb_address_out, .upper_data_or_lsb_address_oe_n,
    .upper_data_or_lsb_address_in, .id_enable_hv, .hard_clear_hv);
  pfc_flash_model u_flash (.flash_pins, .dq_out, .dq_oe_n, .upper_data_or_lsb_address_out,
    .upper_data_or_lsb_address_oe_n, .id_enable_hv, .hard_clear_hv, .dq_in,
    .upper_data_or_lsb_address_in);
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic run(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d,
    input logic [3:0] m);
    int n;
    bus(1'b1, `PFC_REG_ADDR, {11'h0, a});
    bus(1'b1, `PFC_REG_DATA, {16'h0, d});
    bus(1'b1, `PFC_REG_CTRL, {24'h0, m, op, 1'b1});
    n = 0;
    do begin
      bus(1'b0, `PFC_REG_STAT, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 300);
    st = rv;
    bus(1'b0, `PFC_REG_DATA, 32'h0);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #5 core_clk = ~core_clk;
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].d, rows[i].m);
      chk({14'h0, st[1:0]}, 16'h0002);
      if (rows[i].c) chk(rv[15:0], rows[i].q);
    end
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, `PFC_REG_CTRL, 32'h0);
    chk(rv[15:0], 16'h0010);
    bus(1'b0, 4'h1, 32'h0);
    chk(rv[15:0], 16'h0000);
    run(3'h0, 21'h4, 16'h0, 4'h1);
    chk(rv[15:0], 16'h0a04);
    clk_en <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    chk({15'h0, avs_waitrequest}, 16'h0001);
    clk_en <= 1'b1;
    @(posedge core_clk);
    test_done();
  end
endmodule
